// [src/sop_setpoint_params.sv]
/*
 * Setpoint offset, interpolated demand and interpolation period parameters.
 * Assumes one clock per bus access; i_ctrl_tick marks a control cycle and i_sync a sync event.
 */
`timescale 1ns/1ps
// Functional notes
// - velocity unit packs time, position, exponent fields
// - position offset added only in CSP
// - speed offset in CSP, CSV, clock-direction
// - torque offset in CSP, CST, clock-direction
// - demand position taken over at next sync
// - cycle time is period times ten-power exponent
// - period value defaults to one
module sop_setpoint_params
    import sop_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire sop_req_type i_req,
    input wire logic [7:0] i_mode,
    input wire logic i_ctrl_tick,
    input wire logic i_sync,
    input wire sop_set_type i_set,
    output sop_set_type o_set,
    output logic [31:0] o_demand_pos,
    output logic o_demand_valid,
    output logic [7:0] o_period_value,
    output logic signed [7:0] o_period_exp,
    output logic o_ack,
    output sop_ans_type o_ans,
    output logic [31:0] o_rdata
);
    logic [31:0] vel_unit_reg;
    logic [31:0] pos_ofs_reg;
    logic [31:0] spd_ofs_reg;
    logic [15:0] trq_ofs_reg;
    logic [31:0] demand_pend_reg;
    logic pend_reg;
    logic [31:0] demand_reg;
    logic demand_valid_reg;
    logic [7:0] per_val_reg;
    logic [7:0] per_exp_reg;
    sop_set_type set_reg;
    logic ack_reg;
    sop_ans_type ans_reg;
    logic [31:0] rdata_reg;

    function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                                 input logic [15:0] want_idx, input logic [7:0] want_sub);
        hit = (idx == want_idx) && (sub == want_sub);
    endfunction

    // Object decode, subindex 0 for plain variables
    wire logic acc = i_req.wr | i_req.rd;
    wire logic hit_vu = hit(i_req.index, i_req.subindex, IDX_VEL_UNIT, SUB_COUNT);
    wire logic hit_po = hit(i_req.index, i_req.subindex, IDX_POS_OFS, SUB_COUNT);
    wire logic hit_so = hit(i_req.index, i_req.subindex, IDX_SPD_OFS, SUB_COUNT);
    wire logic hit_to = hit(i_req.index, i_req.subindex, IDX_TRQ_OFS, SUB_COUNT);
    wire logic hit_rc = hit(i_req.index, i_req.subindex, IDX_INTERP_REC, SUB_COUNT);
    wire logic hit_rd = hit(i_req.index, i_req.subindex, IDX_INTERP_REC, SUB_FIRST);
    wire logic hit_pc = hit(i_req.index, i_req.subindex, IDX_INTERP_PER, SUB_COUNT);
    wire logic hit_pv = hit(i_req.index, i_req.subindex, IDX_INTERP_PER, SUB_FIRST);
    wire logic hit_pe = hit(i_req.index, i_req.subindex, IDX_INTERP_PER, SUB_SECOND);
    wire logic hit_ro = hit_rc | hit_pc;
    wire logic hit_any = hit_vu | hit_po | hit_so | hit_to | hit_rd | hit_pv | hit_pe | hit_ro;
    wire logic wr_ok = i_req.wr & hit_any & ~hit_ro;

    // Reserved low byte forced to zero on write
    wire logic [31:0] vu_wval = {i_req.wdata[31:VU_TIME_LSB], VU_RSVD_VAL};

    wire logic [31:0] rd_mux =
        hit_vu ? vel_unit_reg :
        hit_po ? pos_ofs_reg :
        hit_so ? spd_ofs_reg :
        hit_to ? {{16{trq_ofs_reg[15]}}, trq_ofs_reg} :
        hit_rc ? {24'h000000, REC_COUNT_VAL} :
        hit_rd ? demand_pend_reg :
        hit_pc ? {24'h000000, PER_COUNT_VAL} :
        hit_pv ? {24'h000000, per_val_reg} :
        hit_pe ? {{24{per_exp_reg[7]}}, per_exp_reg} : ZERO32;

    wire sop_ans_type ans_next = !hit_any ? SOP_ANS_NO_OBJ : (i_req.wr && hit_ro) ? SOP_ANS_RO : SOP_ANS_OK;

    // Mode gating of each offset
    wire logic pos_en = (i_mode == MODE_CSP);
    wire logic spd_en = (i_mode == MODE_CSP) | (i_mode == MODE_CSV) | (i_mode == MODE_CLKDIR);
    wire logic trq_en = (i_mode == MODE_CSP) | (i_mode == MODE_CST) | (i_mode == MODE_CLKDIR);
    wire logic [31:0] pos_add = pos_en ? pos_ofs_reg : ZERO32;
    wire logic [31:0] spd_add = spd_en ? spd_ofs_reg : ZERO32;
    wire logic [15:0] trq_add = trq_en ? trq_ofs_reg : ZERO16;
    wire sop_set_type set_next = '{pos: i_set.pos + pos_add, spd: i_set.spd + spd_add, trq: i_set.trq + trq_add};

    // Register file
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vel_unit_reg <= VEL_UNIT_RST;
            pos_ofs_reg <= POS_OFS_RST;
            spd_ofs_reg <= SPD_OFS_RST;
            trq_ofs_reg <= TRQ_OFS_RST;
            per_val_reg <= PER_VALUE_RST;
            per_exp_reg <= PER_EXP_RST;
        end else if (wr_ok) begin
            if (hit_vu) vel_unit_reg <= vu_wval;
            if (hit_po) pos_ofs_reg <= i_req.wdata;
            if (hit_so) spd_ofs_reg <= i_req.wdata;
            if (hit_to) trq_ofs_reg <= i_req.wdata[15:0];
            if (hit_pv) per_val_reg <= i_req.wdata[7:0];
            if (hit_pe) per_exp_reg <= i_req.wdata[7:0];
        end
    end

    // Demand held pending until the sync event; a write in the sync cycle waits for the next one
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            demand_pend_reg <= DEMAND_RST;
            pend_reg <= 1'b0;
            demand_reg <= DEMAND_RST;
            demand_valid_reg <= 1'b0;
        end else begin
            if (i_sync && pend_reg) begin
                demand_reg <= demand_pend_reg;
            end
            demand_valid_reg <= i_sync & pend_reg;
            if (wr_ok && hit_rd) begin
                demand_pend_reg <= i_req.wdata;
                pend_reg <= 1'b1;
            end else if (i_sync) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // Set values updated once per control cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            set_reg <= '0;
        end else if (i_ctrl_tick) begin
            set_reg <= set_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_reg <= 1'b0;
            ans_reg <= SOP_ANS_OK;
            rdata_reg <= ZERO32;
        end else begin
            ack_reg <= acc;
            ans_reg <= acc ? ans_next : SOP_ANS_OK;
            rdata_reg <= (i_req.rd && hit_any) ? rd_mux : ZERO32;
        end
    end

    assign o_set = set_reg;
    assign o_demand_pos = demand_reg;
    assign o_demand_valid = demand_valid_reg;
    assign o_period_value = per_val_reg;
    assign o_period_exp = per_exp_reg;
    assign o_ack = ack_reg;
    assign o_ans = ans_reg;
    assign o_rdata = rdata_reg;

    AST_VU_RSVD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        vel_unit_reg[VU_TIME_LSB-1:0] == VU_RSVD_VAL) else $error("velocity unit reserved byte not zero");
    AST_POS_GATE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick ##1 1'b1 |-> o_set.pos == $past(i_set.pos) + ($past(i_mode) == MODE_CSP ? $past(pos_ofs_reg) : ZERO32))
        else $error("position offset gating wrong");
    AST_SPD_GATE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode != MODE_CSP && i_mode != MODE_CSV && i_mode != MODE_CLKDIR
        |=> o_set.spd == $past(i_set.spd))
        else $error("speed offset applied in excluded mode");
    AST_SPD_ADD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode == MODE_CSV |=> o_set.spd == $past(i_set.spd) + $past(spd_ofs_reg))
        else $error("speed offset not applied in CSV");
    AST_TRQ_GATE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode == MODE_CSV |=> o_set.trq == $past(i_set.trq)) else $error("torque offset in CSV");
    AST_TRQ_ADD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode == MODE_CST |=> o_set.trq == $past(i_set.trq) + $past(trq_ofs_reg))
        else $error("torque offset not applied in CST");
    AST_DEMAND_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_sync |=> $stable(o_demand_pos)) else $error("demand changed without sync");
    AST_DEMAND_TAKE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ok && hit_rd ##1 i_sync |=> o_demand_pos == $past(i_req.wdata, 2) && o_demand_valid)
        else $error("demand not taken at sync");
    AST_PER_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ok && hit_pv |=> o_period_value == $past(i_req.wdata[7:0])) else $error("period value not written");
    AST_NO_TICK: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_ctrl_tick |=> $stable(o_set)) else $error("set values changed off cycle");

    // Access port answer: one-cycle acknowledge, code and data
    AST_ACK_ANSWER: assert property (@(posedge i_clk) disable iff (!i_rstn)
        acc |=> o_ack)
        else $error("access not acknowledged");
    AST_ACK_IDLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !acc |=> !o_ack)
        else $error("acknowledge without access");
    AST_ANS_MISS: assert property (@(posedge i_clk) disable iff (!i_rstn)
        acc && !hit_any |=> o_ans == SOP_ANS_NO_OBJ && o_rdata == ZERO32)
        else $error("unknown object not refused");
    AST_ANS_RO: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.wr && hit_ro |=> o_ans == SOP_ANS_RO)
        else $error("write to read-only entry not refused");
    AST_ANS_OK: assert property (@(posedge i_clk) disable iff (!i_rstn)
        acc && hit_any && !(i_req.wr && hit_ro) |=> o_ans == SOP_ANS_OK)
        else $error("legal access refused");
    AST_ANS_IDLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !acc |=> o_ans == SOP_ANS_OK)
        else $error("answer code without access");
    AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_req.rd |=> o_rdata == ZERO32)
        else $error("read data without read");
    AST_REC_COUNT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_rc |=> o_rdata == {24'h000000, REC_COUNT_VAL})
        else $error("record entry count wrong");
    AST_PER_COUNT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_pc |=> o_rdata == {24'h000000, PER_COUNT_VAL})
        else $error("period entry count wrong");

    // Register writes land only on a legal hit, reads return the held value
    AST_VU_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ok && hit_vu |=> vel_unit_reg == {$past(i_req.wdata[31:VU_TIME_LSB]), VU_RSVD_VAL})
        else $error("velocity unit fields not written");
    AST_VU_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !(wr_ok && hit_vu) |=> $stable(vel_unit_reg))
        else $error("velocity unit changed without write");
    AST_VU_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_vu |=> o_rdata == $past(vel_unit_reg))
        else $error("velocity unit read wrong");
    AST_PO_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ok && hit_po |=> pos_ofs_reg == $past(i_req.wdata))
        else $error("position offset not written");
    AST_PO_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_po |=> o_rdata == $past(pos_ofs_reg))
        else $error("position offset read wrong");
    AST_SO_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ok && hit_so |=> spd_ofs_reg == $past(i_req.wdata))
        else $error("speed offset not written");
    AST_SO_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_so |=> o_rdata == $past(spd_ofs_reg))
        else $error("speed offset read wrong");
    AST_TO_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ok && hit_to |=> trq_ofs_reg == $past(i_req.wdata[15:0]))
        else $error("torque offset not written");
    AST_TO_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_to |=> $signed(o_rdata) == $signed($past(trq_ofs_reg)))
        else $error("torque offset read not sign-extended");
    AST_OFS_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !wr_ok |=> $stable(pos_ofs_reg) && $stable(spd_ofs_reg) && $stable(trq_ofs_reg))
        else $error("offset changed without write");
    AST_MISS_NO_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.wr && (!hit_any || hit_ro) |=> $stable(vel_unit_reg) && $stable(per_val_reg) && $stable(per_exp_reg))
        else $error("refused write changed a register");

    // Interpolation period fields
    AST_PV_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !(wr_ok && hit_pv) |=> $stable(o_period_value))
        else $error("period value changed without write");
    AST_PV_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_pv |=> o_rdata == {24'h000000, $past(o_period_value)})
        else $error("period value read wrong");
    AST_PE_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ok && hit_pe |=> o_period_exp == $signed($past(i_req.wdata[7:0])))
        else $error("period exponent not written");
    AST_PE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !(wr_ok && hit_pe) |=> $stable(o_period_exp))
        else $error("period exponent changed without write");
    AST_PE_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_pe |=> $signed(o_rdata) == $past(o_period_exp))
        else $error("period exponent read not sign-extended");

    // Offset gating in the remaining modes, modes spelled out against the decode
    AST_PO_EXCL: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode != MODE_CSP |=> o_set.pos == $past(i_set.pos))
        else $error("position offset applied outside CSP");
    AST_SPD_CSP: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode == MODE_CSP |=> o_set.spd == $past(i_set.spd) + $past(spd_ofs_reg))
        else $error("speed offset not applied in CSP");
    AST_SPD_CLKDIR: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode == MODE_CLKDIR |=> o_set.spd == $past(i_set.spd) + $past(spd_ofs_reg))
        else $error("speed offset not applied in clock-direction mode");
    AST_TRQ_CSP: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode == MODE_CSP |=> o_set.trq == $past(i_set.trq) + $past(trq_ofs_reg))
        else $error("torque offset not applied in CSP");
    AST_TRQ_CLKDIR: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode == MODE_CLKDIR |=> o_set.trq == $past(i_set.trq) + $past(trq_ofs_reg))
        else $error("torque offset not applied in clock-direction mode");
    AST_TRQ_EXCL: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ctrl_tick && i_mode != MODE_CSP && i_mode != MODE_CST && i_mode != MODE_CLKDIR
        |=> o_set.trq == $past(i_set.trq))
        else $error("torque offset applied in excluded mode");

    // Demand takeover: a write in a sync cycle waits, an empty sync does nothing
    AST_DEMAND_LATE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ok && hit_rd && i_sync |=> pend_reg && demand_pend_reg == $past(i_req.wdata))
        else $error("write in sync cycle not kept pending");
    AST_SYNC_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_sync && !(wr_ok && hit_rd) |=> !pend_reg)
        else $error("pending demand not cleared at sync");
    AST_VALID_ONLY: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !(i_sync && pend_reg) |=> !o_demand_valid)
        else $error("demand valid without takeover");
    AST_VALID_DEMAND: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_demand_valid |-> o_demand_pos == $past(demand_pend_reg))
        else $error("taken demand differs from pending value");
    AST_RD_PEND: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.rd && hit_rd |=> o_rdata == $past(demand_pend_reg))
        else $error("demand read does not return pending value");
endmodule // sop_setpoint_params

// [src/sop_pkg.sv]
/*
 * Package for the setpoint offset and interpolation parameter block.
 * Holds object indices, subindices, field layouts, reset values, mode codes and carrier types.
 * Assumes an object-dictionary style access port: 16-bit index, 8-bit subindex, 32-bit data.
 */
package sop_pkg;
    localparam logic [15:0] IDX_VEL_UNIT = 16'h60a9;
    localparam logic [15:0] IDX_POS_OFS = 16'h60b0;
    localparam logic [15:0] IDX_SPD_OFS = 16'h60b1;
    localparam logic [15:0] IDX_TRQ_OFS = 16'h60b2;
    localparam logic [15:0] IDX_INTERP_REC = 16'h60c1;
    localparam logic [15:0] IDX_INTERP_PER = 16'h60c2;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_FIRST = 8'h01;
    localparam logic [7:0] SUB_SECOND = 8'h02;
    localparam int VU_TIME_LSB = 8;
    localparam int VU_POS_LSB = 16;
    localparam int VU_EXP_LSB = 24;
    localparam logic [7:0] VU_RSVD_VAL = 8'h00;
    localparam logic [31:0] VEL_UNIT_RST = 32'h00b44700;
    localparam logic [31:0] POS_OFS_RST = 32'h00000000;
    localparam logic [31:0] SPD_OFS_RST = 32'h00000000;
    localparam logic [15:0] TRQ_OFS_RST = 16'h0000;
    localparam logic [31:0] DEMAND_RST = 32'h00000000;
    localparam logic [7:0] REC_COUNT_VAL = 8'h01;
    localparam logic [7:0] PER_COUNT_VAL = 8'h02;
    localparam logic [7:0] PER_VALUE_RST = 8'h01;
    localparam logic [7:0] PER_EXP_RST = 8'hfd;
    localparam logic [31:0] ZERO32 = 32'h00000000;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] ZERO8 = 8'h00;
    // Operating mode codes of the mode-of-operation object
    localparam logic [7:0] MODE_IP = 8'h07;
    localparam logic [7:0] MODE_CSP = 8'h08;
    localparam logic [7:0] MODE_CSV = 8'h09;
    localparam logic [7:0] MODE_CST = 8'h0a;
    localparam logic [7:0] MODE_CLKDIR = 8'hff;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } sop_req_type;

    typedef struct packed {
        logic [31:0] pos;
        logic [31:0] spd;
        logic [15:0] trq;
    } sop_set_type;

    typedef enum logic [1:0] {
        SOP_ANS_OK = 2'b00,
        SOP_ANS_NO_OBJ = 2'b01,
        SOP_ANS_RO = 2'b10
    } sop_ans_type;
endpackage

// [bench/sop_master_model.sv]
/*
 * Fieldbus master model: issues object reads and writes on the access port.
 * Assumes the block answers each access with a one-cycle ack one edge after it is taken.
 */
`timescale 1ns/1ps
module sop_master_model
    import sop_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ack,
    input wire sop_ans_type i_ans,
    input wire logic [31:0] i_rdata,
    output sop_req_type o_req
);
    // Master programs a millisecond time base
    localparam logic [7:0] EXP_MS = 8'hfd;

    initial o_req = '0;

    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                          output sop_ans_type ans, output logic [31:0] rd, output logic hung);
        hung = 1'b1;
        ans = SOP_ANS_OK;
        rd = '0;
        @(posedge i_clk);
        o_req <= '{wr: wr, rd: !wr, index: idx, subindex: sub, wdata: wd};
        @(posedge i_clk);
        // Request stands for its one taking edge; released lines show inverted leftovers
        o_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, subindex: ~sub, wdata: ~wd};
        for (int i = 0; i < 4; i++) begin
            // Answer taken at the edge that samples the acknowledge
            @(posedge i_clk);
            if (i_ack === 1'b1) begin
                ans = i_ans;
                rd = i_rdata;
                hung = 1'b0;
                break;
            end
        end
    endtask
endmodule // sop_master_model

// [bench/tb_top.sv]
/*
 * Self-checking bench: registers, offset gating per mode, demand takeover.
 * Assumes the master model drives the access port; bench drives mode, ticks and sync.
 */
`timescale 1ns/1ps
module tb_top;
    import sop_pkg::*;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_ctrl_tick = 1'b0, i_sync = 1'b0;
    logic [7:0] i_mode = MODE_IP;
    logic [7:0] m;
    sop_set_type i_set = '0;
    sop_req_type req;
    sop_set_type o_set;
    logic [31:0] o_demand_pos, o_rdata;
    logic o_demand_valid, o_ack;
    logic [7:0] o_period_value;
    logic signed [7:0] o_period_exp;
    sop_ans_type o_ans;
    logic [7:0] modes [5] = '{MODE_IP, MODE_CSP, MODE_CSV, MODE_CST, MODE_CLKDIR};
    int n_mismatch = 0, n_tests = 0;

    always #2 i_clk = ~i_clk;

    sop_master_model M (.i_clk(i_clk), .i_ack(o_ack), .i_ans(o_ans), .i_rdata(o_rdata), .o_req(req));
    sop_setpoint_params DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .i_mode(i_mode),
        .i_ctrl_tick(i_ctrl_tick), .i_sync(i_sync), .i_set(i_set), .o_set(o_set), .o_demand_pos(o_demand_pos),
        .o_demand_valid(o_demand_valid), .o_period_value(o_period_value), .o_period_exp(o_period_exp),
        .o_ack(o_ack), .o_ans(o_ans), .o_rdata(o_rdata));

    task automatic conclude();
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_ans(input sop_ans_type exp, input sop_ans_type got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value answer expected %h seen %h", exp, got);
        end
    endtask

    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                       input sop_ans_type ea, input logic [31:0] er);
        sop_ans_type a;
        logic [31:0] r;
        logic h;
        M.access(wr, idx, sub, wd, a, r, h);
        if (h) begin
            n_mismatch++;
            $display("wrong value ack expected 1 seen 0");
            conclude();
        end else begin
            chk_ans(ea, a);
            chk("read data", er, r);
        end
    endtask

    task automatic sync_pulse();
        @(posedge i_clk);
        i_sync <= 1'b1;
        @(posedge i_clk);
        i_sync <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (8) @(posedge i_clk);
        chk("period value", 32'h00000001, {24'h0, o_period_value});
        chk("period exp", 32'h000000fd, {24'h0, o_period_exp});
        i_rstn <= 1'b1;
        acc(1'b0, 16'h60a9, 8'h00, 32'h0, SOP_ANS_OK, 32'h00b44700);
        acc(1'b1, 16'h60a9, 8'h00, 32'hffffffff, SOP_ANS_OK, 32'h0);
        acc(1'b0, 16'h60a9, 8'h00, 32'h0, SOP_ANS_OK, 32'hffffff00);
        acc(1'b0, 16'h60c1, 8'h00, 32'h0, SOP_ANS_OK, 32'h00000001);
        acc(1'b0, 16'h60c2, 8'h00, 32'h0, SOP_ANS_OK, 32'h00000002);
        acc(1'b0, 16'h60c2, 8'h01, 32'h0, SOP_ANS_OK, 32'h00000001);
        acc(1'b0, 16'h60c2, 8'h02, 32'h0, SOP_ANS_OK, 32'hfffffffd);
        acc(1'b1, 16'h60c1, 8'h00, 32'h5, SOP_ANS_RO, 32'h0);
        acc(1'b1, 16'h60c2, 8'h00, 32'h5, SOP_ANS_RO, 32'h0);
        acc(1'b0, 16'h6000, 8'h00, 32'h0, SOP_ANS_NO_OBJ, 32'h0);
        acc(1'b1, 16'h60c2, 8'h01, 32'h0000000a, SOP_ANS_OK, 32'h0);
        acc(1'b1, 16'h60c2, 8'h02, 32'h000000fa, SOP_ANS_OK, 32'h0);
        acc(1'b0, 16'h60c2, 8'h02, 32'h0, SOP_ANS_OK, 32'hfffffffa);
        acc(1'b1, 16'h60c2, 8'h02, {24'h0, M.EXP_MS}, SOP_ANS_OK, 32'h0);
        chk("period value", 32'h0000000a, {24'h0, o_period_value});
        chk("period exp", 32'h000000fd, {24'h0, o_period_exp});
        acc(1'b1, 16'h60b0, 8'h00, 32'h00000010, SOP_ANS_OK, 32'h0);
        acc(1'b1, 16'h60b1, 8'h00, 32'hfffffff0, SOP_ANS_OK, 32'h0);
        acc(1'b1, 16'h60b2, 8'h00, 32'h0000ffff, SOP_ANS_OK, 32'h0);
        acc(1'b0, 16'h60b2, 8'h00, 32'h0, SOP_ANS_OK, 32'hffffffff);
        for (int k = 0; k < 5; k++) begin
            m = modes[k];
            @(posedge i_clk);
            i_mode <= m;
            i_set <= '{pos: 32'hffffffff, spd: 32'h00000100, trq: 16'h0005};
            i_ctrl_tick <= 1'b1;
            @(posedge i_clk);
            i_ctrl_tick <= 1'b0;
            #1;
            chk("pos set", (m == MODE_CSP) ? 32'h0000000f : 32'hffffffff, o_set.pos);
            chk("spd set", (m == MODE_CSP || m == MODE_CSV || m == MODE_CLKDIR) ? 32'h000000f0 : 32'h00000100,
                o_set.spd);
            chk("trq set", {16'h0, (m == MODE_CSP || m == MODE_CST || m == MODE_CLKDIR) ? 16'h0004 : 16'h0005},
                {16'h0, o_set.trq});
        end
        acc(1'b1, 16'h60c1, 8'h01, 32'h12345678, SOP_ANS_OK, 32'h0);
        acc(1'b0, 16'h60c1, 8'h01, 32'h0, SOP_ANS_OK, 32'h12345678);
        chk("demand before sync", 32'h0, o_demand_pos);
        sync_pulse();
        chk("demand", 32'h12345678, o_demand_pos);
        chk("demand valid", 32'h1, {31'h0, o_demand_valid});
        sync_pulse();
        chk("idle sync valid", 32'h0, {31'h0, o_demand_valid});
        // Write taken in the same cycle as a sync waits for the next sync
        fork
            acc(1'b1, 16'h60c1, 8'h01, 32'h00a5a5a5, SOP_ANS_OK, 32'h0);
            begin
                @(posedge i_clk);
                i_sync <= 1'b1;
                @(posedge i_clk);
                i_sync <= 1'b0;
            end
        join
        chk("demand at write sync", 32'h12345678, o_demand_pos);
        sync_pulse();
        chk("late demand", 32'h00a5a5a5, o_demand_pos);
        chk("late demand valid", 32'h1, {31'h0, o_demand_valid});
        // Mid-run reset brings back the preset values
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("demand in reset", 32'h0, o_demand_pos);
        i_rstn <= 1'b1;
        acc(1'b0, 16'h60a9, 8'h00, 32'h0, SOP_ANS_OK, 32'h00b44700);
        acc(1'b0, 16'h60b1, 8'h00, 32'h0, SOP_ANS_OK, 32'h0);
        acc(1'b0, 16'h60c2, 8'h01, 32'h0, SOP_ANS_OK, 32'h00000001);
        acc(1'b0, 16'h60c1, 8'h01, 32'h0, SOP_ANS_OK, 32'h0);
        conclude();
    end
endmodule // tb_top
